/* shared/scsl_pkg.sv */
// constants and types shared by the slot-identity and led status block
package scsl_pkg;
    // bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] SLOT_OFFS     = 8'h00;
    localparam logic [7:0] MODE_OFFS     = 8'h04;
    localparam logic [7:0] LED_OFFS      = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFFS = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFFS = 8'h10;
    localparam logic [7:0] NAME_OFFS     = 8'h14;
    // field positions
    localparam int SLOT_NUM_LSB   = 0;
    localparam int SLOT_VALID_BIT = 4;
    localparam int SLOT_BAD_BIT   = 5;
    localparam int SLOT_POS_LSB   = 8;
    localparam int LED_LINK_LSB   = 0;
    localparam int LED_ACT_LSB    = 4;
    localparam int IRQ_BAD_BIT    = 0;
    localparam int IRQ_LINK_LSB   = 1;
    localparam int NAME_BYTE_W    = 8;
    // sizes
    localparam int MAX_PORTS = 4;
    localparam int SWITCH_W  = 3;
    localparam int SLOT_W    = 4;
    localparam int IRQ_W     = 1 + MAX_PORTS;
    // positions accepted per variant
    localparam int VALID_POS_FOUR = 3;
    localparam int VALID_POS_TWO  = 2;
    // reset values
    localparam logic [MAX_PORTS-1:0] MODE_RST     = 4'h0;
    localparam logic [IRQ_W-1:0]     IRQ_MASK_RST = 5'h00;
    // activity blink on-time
    localparam int CLK_FREQ_HZ     = 10_000_000;
    localparam int BLINK_TIME_MS   = 50;
    localparam int BLINK_CYCLES    = BLINK_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int BLINK_CNT_W     = 20;
    // blink stretcher states
    typedef enum logic {
        BLINK_IDLE,
        BLINK_ON
    } scsl_blink_state_e;
endpackage

/* rtl/scsl_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module scsl_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             sys_rst_in,
    // data
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } scsl_sync_s;

    scsl_sync_s st_reg;
    scsl_sync_s st_next;

    // meta feeds only the second stage
    always_comb begin
        st_next.meta   = d_in;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_out = st_reg.stable;
endmodule

/* rtl/scsl_blink.sv */
// stretches one frame event into a visible activity blink
`timescale 1ns/10ps
module scsl_blink
    import scsl_pkg::*;
#(
    parameter int CNT_W     = scsl_pkg::BLINK_CNT_W,
    parameter int ON_CYCLES = scsl_pkg::BLINK_CYCLES
) (
    // clock and reset
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    // frame event and lamp
    input  wire logic frame_evt_in,
    output logic      led_out
);
    typedef struct packed {
        scsl_blink_state_e state;
        logic [CNT_W-1:0]  cnt;
        logic              led;
    } scsl_blink_s;

    localparam logic [CNT_W-1:0] LOAD = CNT_W'(ON_CYCLES - 1);

    scsl_blink_s st_reg;
    scsl_blink_s st_next;

    // a new frame reloads the timer so bursts look like one long blink
    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            BLINK_IDLE: begin
                if (frame_evt_in) begin
                    st_next.state = BLINK_ON;
                    st_next.cnt   = LOAD;
                end
            end
            BLINK_ON: begin
                if (frame_evt_in) begin
                    st_next.cnt = LOAD;
                end else if (st_reg.cnt == '0) begin
                    st_next.state = BLINK_IDLE;
                end else begin
                    st_next.cnt = st_reg.cnt - 1'b1;
                end
            end
            default: begin
                st_next.state = BLINK_IDLE;
            end
        endcase
        st_next.led = (st_next.state == BLINK_ON);
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '{state: BLINK_IDLE, cnt: '0, led: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign led_out = st_reg.led;
endmodule

/* rtl/scsl_top.sv */
// slot identity decode, port naming and per-port led status for a serial card
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/10ps

// Functional notes
// - slot is switch position plus one
// - switch read as three bits, eight positions
// - four-port accepts 0-2, two-port 0-1
// - each port independently terminal or circuit side
// - one activity blink per burst of frames
// - terminal side: link on with DSR, DCD, CTS
// - ports 2 and 3 lamps on four-port only
module scsl_top
    import scsl_pkg::*;
#(
    parameter int PORT_COUNT    = 4,
    parameter int BLINK_CYCLES_P = scsl_pkg::BLINK_CYCLES
) (
    // clock and reset
    input  wire logic                            core_clk_in,
    input  wire logic                            sys_rst_in,
    // register port
    input  wire logic [scsl_pkg::ADDR_W-1:0]     reg_addr_in,
    input  wire logic [scsl_pkg::DATA_W-1:0]     reg_wdata_in,
    input  wire logic                            reg_wr_in,
    input  wire logic                            reg_rd_in,
    output logic      [scsl_pkg::DATA_W-1:0]     reg_rdata_out,
    // rotary switch pins
    input  wire logic [scsl_pkg::SWITCH_W-1:0]   rotary_switch_in,
    // modem control pins, one bit per port
    input  wire logic [scsl_pkg::MAX_PORTS-1:0]  dsr_in,
    input  wire logic [scsl_pkg::MAX_PORTS-1:0]  dcd_in,
    input  wire logic [scsl_pkg::MAX_PORTS-1:0]  cts_in,
    input  wire logic [scsl_pkg::MAX_PORTS-1:0]  dtr_in,
    input  wire logic [scsl_pkg::MAX_PORTS-1:0]  rts_in,
    // frame events from the serial engines
    input  wire logic [scsl_pkg::MAX_PORTS-1:0]  tx_frame_in,
    input  wire logic [scsl_pkg::MAX_PORTS-1:0]  rx_frame_in,
    // slot identity
    output logic      [scsl_pkg::SLOT_W-1:0]     card_slot_number_out,
    output logic                                 slot_valid_out,
    output logic                                 switch_bad_out,
    output logic      [scsl_pkg::DATA_W-1:0]     port_name_out,
    // front-panel lamps
    output logic                                 port0_activity_led_out,
    output logic                                 port0_link_led_out,
    output logic                                 port1_activity_led_out,
    output logic                                 port1_link_led_out,
    output logic                                 port2_activity_led_out,
    output logic                                 port2_link_led_out,
    output logic                                 port3_activity_led_out,
    output logic                                 port3_link_led_out,
    // interrupt
    output logic                                 irq_out
);
    localparam int MODEM_W = 5 * MAX_PORTS;
    localparam int VALID_POS =
        (PORT_COUNT == MAX_PORTS) ? VALID_POS_FOUR : VALID_POS_TWO;
    localparam logic [MAX_PORTS-1:0] PORT_MASK =
        MAX_PORTS'((1 << PORT_COUNT) - 1);

    typedef struct packed {
        logic [SLOT_W-1:0]    slot_num;
        logic                 slot_valid;
        logic                 switch_bad;
        logic [MAX_PORTS-1:0] dce_mode;
        logic [MAX_PORTS-1:0] link_led;
        logic [IRQ_W-1:0]     irq_status;
        logic [IRQ_W-1:0]     irq_mask;
        logic                 irq;
        logic [DATA_W-1:0]    rd_data;
        logic [DATA_W-1:0]    port_names;
    } scsl_top_s;

    scsl_top_s st_reg;
    scsl_top_s st_next;

    logic [SWITCH_W-1:0]  sw_sync;
    logic [MODEM_W-1:0]   modem_sync;
    logic [MAX_PORTS-1:0] dsr_s;
    logic [MAX_PORTS-1:0] dcd_s;
    logic [MAX_PORTS-1:0] cts_s;
    logic [MAX_PORTS-1:0] dtr_s;
    logic [MAX_PORTS-1:0] rts_s;
    logic [MAX_PORTS-1:0] act_led;

    // true when the position is accepted by this variant
    function automatic logic pos_ok(input logic [SWITCH_W-1:0] pos);
        pos_ok = ({1'b0, pos} < (SWITCH_W+1)'(VALID_POS));
    endfunction

    // slot number shown for a switch position
    function automatic logic [SLOT_W-1:0] slot_of(input logic [SWITCH_W-1:0] pos);
        slot_of = {1'b0, pos} + 4'h1;
    endfunction

    // link lamp condition for one port in its selected role
    function automatic logic link_of(
        input logic dce,
        input logic dsr,
        input logic dcd,
        input logic cts,
        input logic dtr,
        input logic rts
    );
        if (dce) begin
            link_of = dtr & rts;
        end else begin
            link_of = dsr & dcd & cts;
        end
    endfunction

    // all three switch bits synchronised: eight positions
    scsl_sync #(
        .WIDTH (SWITCH_W)
    ) u_sw_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .d_in        (rotary_switch_in),
        .q_out       (sw_sync)
    );

    // modem lines are asynchronous to the core clock
    scsl_sync #(
        .WIDTH (MODEM_W)
    ) u_modem_sync (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .d_in        ({rts_in, dtr_in, cts_in, dcd_in, dsr_in}),
        .q_out       (modem_sync)
    );

    // split the synchronised modem bundle
    assign dsr_s = modem_sync[0*MAX_PORTS +: MAX_PORTS];
    assign dcd_s = modem_sync[1*MAX_PORTS +: MAX_PORTS];
    assign cts_s = modem_sync[2*MAX_PORTS +: MAX_PORTS];
    assign dtr_s = modem_sync[3*MAX_PORTS +: MAX_PORTS];
    assign rts_s = modem_sync[4*MAX_PORTS +: MAX_PORTS];

    // one stretcher per port; absent ports never see an event
    generate
        for (genvar p = 0; p < MAX_PORTS; p++) begin : g_act
            logic evt;
            assign evt = (tx_frame_in[p] | rx_frame_in[p]) & PORT_MASK[p];
            scsl_blink #(
                .CNT_W     (BLINK_CNT_W),
                .ON_CYCLES (BLINK_CYCLES_P)
            ) u_blink (
                .core_clk_in  (core_clk_in),
                .sys_rst_in   (sys_rst_in),
                .frame_evt_in (evt),
                .led_out      (act_led[p])
            );
        end
    endgenerate

    // decode, lamps, events and register access in one pass
    always_comb begin
        logic                 bad_now;
        logic [MAX_PORTS-1:0] link_now;
        logic [IRQ_W-1:0]     evt;
        logic [IRQ_W-1:0]     clr;
        bad_now  = 1'b0;
        link_now = '0;
        evt      = '0;
        clr      = '0;
        st_next  = st_reg;

        // slot identity; a bad position hides the slot number
        bad_now            = !pos_ok(sw_sync);
        st_next.switch_bad = bad_now;
        st_next.slot_valid = !bad_now;
        st_next.slot_num   = bad_now ? 4'h0 : slot_of(sw_sync);

        // names: one byte per port, absent ports zero
        for (int p = 0; p < MAX_PORTS; p++) begin
            if (PORT_MASK[p] && !bad_now) begin
                st_next.port_names[p*NAME_BYTE_W +: NAME_BYTE_W] =
                    {slot_of(sw_sync), 4'(p)};
            end else begin
                st_next.port_names[p*NAME_BYTE_W +: NAME_BYTE_W] = 8'h00;
            end
        end

        // link lamps follow the role bit of each port
        for (int p = 0; p < MAX_PORTS; p++) begin
            link_now[p] = PORT_MASK[p] & link_of(st_reg.dce_mode[p],
                dsr_s[p], dcd_s[p], cts_s[p], dtr_s[p], rts_s[p]);
        end
        st_next.link_led = link_now;

        // events: entering a bad position, and any link lamp change
        evt[IRQ_BAD_BIT] = bad_now & ~st_reg.switch_bad;
        evt[IRQ_LINK_LSB +: MAX_PORTS] = link_now ^ st_reg.link_led;

        // register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                MODE_OFFS: begin
                    // role bits of absent ports stay zero
                    st_next.dce_mode = reg_wdata_in[MAX_PORTS-1:0] & PORT_MASK;
                end
                IRQ_STAT_OFFS: begin
                    clr = reg_wdata_in[IRQ_W-1:0];
                end
                IRQ_MASK_OFFS: begin
                    st_next.irq_mask = reg_wdata_in[IRQ_W-1:0];
                end
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end

        // a new event in the clearing cycle survives the clear
        st_next.irq_status = (st_reg.irq_status & ~clr) | evt;
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        // read data stand in the cycle after the strobe only
        st_next.rd_data = '0;
        if (reg_rd_in) begin
            case (reg_addr_in)
                SLOT_OFFS: begin
                    st_next.rd_data[SLOT_NUM_LSB +: SLOT_W]   = st_reg.slot_num;
                    st_next.rd_data[SLOT_VALID_BIT]           = st_reg.slot_valid;
                    st_next.rd_data[SLOT_BAD_BIT]             = st_reg.switch_bad;
                    st_next.rd_data[SLOT_POS_LSB +: SWITCH_W] = sw_sync;
                end
                MODE_OFFS: begin
                    st_next.rd_data[MAX_PORTS-1:0] = st_reg.dce_mode;
                end
                LED_OFFS: begin
                    st_next.rd_data[LED_LINK_LSB +: MAX_PORTS] = st_reg.link_led;
                    st_next.rd_data[LED_ACT_LSB +: MAX_PORTS]  = act_led;
                end
                IRQ_STAT_OFFS: begin
                    st_next.rd_data[IRQ_W-1:0] = st_reg.irq_status;
                end
                IRQ_MASK_OFFS: begin
                    st_next.rd_data[IRQ_W-1:0] = st_reg.irq_mask;
                end
                NAME_OFFS: begin
                    st_next.rd_data = st_reg.port_names;
                end
                default: begin
                    st_next.rd_data = '0;
                end
            endcase
        end
    end

    // state register; ports start terminal side
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg            <= '0;
            st_reg.dce_mode   <= MODE_RST;
            st_reg.irq_mask   <= IRQ_MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign reg_rdata_out          = st_reg.rd_data;
    assign card_slot_number_out   = st_reg.slot_num;
    assign slot_valid_out         = st_reg.slot_valid;
    assign switch_bad_out         = st_reg.switch_bad;
    assign port_name_out          = st_reg.port_names;
    assign irq_out                = st_reg.irq;
    assign port0_activity_led_out = act_led[0];
    assign port1_activity_led_out = act_led[1];
    assign port2_activity_led_out = act_led[2];
    assign port3_activity_led_out = act_led[3];
    assign port0_link_led_out     = st_reg.link_led[0];
    assign port1_link_led_out     = st_reg.link_led[1];
    assign port2_link_led_out     = st_reg.link_led[2];
    assign port3_link_led_out     = st_reg.link_led[3];
endmodule

/* tb/scsl_sva.sv */
// concurrent checks on the slot decode, lamp and read port outputs
`timescale 1ns/10ps
module scsl_sva
    import scsl_pkg::*;
#(
    parameter int PORT_COUNT     = 4,
    parameter int BLINK_CYCLES_P = 8
) (
    // clock and reset
    input wire logic                            core_clk_in,
    input wire logic                            sys_rst_in,
    // register port
    input wire logic [scsl_pkg::ADDR_W-1:0]     reg_addr_in,
    input wire logic [scsl_pkg::DATA_W-1:0]     reg_wdata_in,
    input wire logic                            reg_wr_in,
    input wire logic                            reg_rd_in,
    input wire logic [scsl_pkg::DATA_W-1:0]     reg_rdata_out,
    // pins and frame events
    input wire logic [scsl_pkg::SWITCH_W-1:0]   rotary_switch_in,
    input wire logic [scsl_pkg::MAX_PORTS-1:0]  dsr_in,
    input wire logic [scsl_pkg::MAX_PORTS-1:0]  dcd_in,
    input wire logic [scsl_pkg::MAX_PORTS-1:0]  cts_in,
    input wire logic [scsl_pkg::MAX_PORTS-1:0]  dtr_in,
    input wire logic [scsl_pkg::MAX_PORTS-1:0]  rts_in,
    input wire logic [scsl_pkg::MAX_PORTS-1:0]  tx_frame_in,
    input wire logic [scsl_pkg::MAX_PORTS-1:0]  rx_frame_in,
    // outputs watched
    input wire logic [scsl_pkg::SLOT_W-1:0]     card_slot_number_out,
    input wire logic                            slot_valid_out,
    input wire logic                            switch_bad_out,
    input wire logic [scsl_pkg::DATA_W-1:0]     port_name_out,
    input wire logic                            port0_activity_led_out,
    input wire logic                            port0_link_led_out,
    input wire logic                            port2_activity_led_out,
    input wire logic                            port2_link_led_out
);
    localparam int VMAX = (PORT_COUNT == 4) ? VALID_POS_FOUR : VALID_POS_TWO;
    // port 0 role, line quiet time, blink left
    typedef struct packed {
        logic        mode;
        logic [4:0]  pins;
        logic [3:0]  stab;
        logic [31:0] blink;
    } scsl_chk_s;
    scsl_chk_s  chk_reg, chk_next;
    logic [4:0] pins_now;
    logic       mode_wr;
    assign pins_now = {dsr_in[0], dcd_in[0], cts_in[0], dtr_in[0], rts_in[0]};
    assign mode_wr = reg_wr_in && (reg_addr_in == MODE_OFFS);
    // judge the lamp only once lines sat still past the synchroniser
    always_comb begin
        chk_next = chk_reg;
        chk_next.pins = pins_now;
        if (mode_wr)
            chk_next.mode = reg_wdata_in[0];
        if (mode_wr || pins_now != chk_reg.pins)
            chk_next.stab = 4'h0;
        else if (chk_reg.stab != 4'hf)
            chk_next.stab = chk_reg.stab + 4'h1;
        if (tx_frame_in[0] || rx_frame_in[0])
            chk_next.blink = BLINK_CYCLES_P;
        else if (chk_reg.blink != 0)
            chk_next.blink = chk_reg.blink - 1;
    end
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in)
            chk_reg <= '0;
        else
            chk_reg <= chk_next;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_sw_still;
        $stable(rotary_switch_in) [*4];
    endsequence
    a_switch_decode: assert property (s_sw_still |=> card_slot_number_out ==
        (($past(rotary_switch_in) < VMAX) ? {1'b0, $past(rotary_switch_in)} + 4'h1 : 4'h0))
        else $error("slot number does not follow the switch");
    a_slot_range: assert property (slot_valid_out |-> card_slot_number_out >= 4'h1
        && card_slot_number_out <= VMAX) else $error("valid slot out of range");
    a_name_form: assert property (slot_valid_out |-> port_name_out[15:0] ==
        {card_slot_number_out, 4'h1, card_slot_number_out, 4'h0}) else $error("bad port name");
    a_bad_no_slot: assert property (switch_bad_out |-> !slot_valid_out
        && card_slot_number_out == 4'h0 && port_name_out == '0) else $error("bad switch gives slot");
    a_absent_ports: assert property (PORT_COUNT == 2 |-> port_name_out[31:16] == 16'h0
        && !port2_activity_led_out && !port2_link_led_out) else $error("absent port shows");
    a_blink_len: assert property (port0_activity_led_out == (chk_reg.blink != 0))
        else $error("activity blink length wrong");
    a_link_follow: assert property (chk_reg.stab >= 4'h4 |-> port0_link_led_out ==
        (chk_reg.mode ? (dtr_in[0] & rts_in[0]) : (dsr_in[0] & dcd_in[0] & cts_in[0])))
        else $error("link lamp disagrees with lines");
    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
        else $error("read data outside answer cycle");
endmodule
bind scsl_top scsl_sva #(.PORT_COUNT(PORT_COUNT), .BLINK_CYCLES_P(BLINK_CYCLES_P)) u_sva (
    .core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .rotary_switch_in, .dsr_in, .dcd_in, .cts_in, .dtr_in, .rts_in,
    .tx_frame_in, .rx_frame_in, .card_slot_number_out, .slot_valid_out, .switch_bad_out,
    .port_name_out, .port0_activity_led_out, .port0_link_led_out, .port2_activity_led_out,
    .port2_link_led_out);

/* tb/scsl_line_model.sv */
// far-end serial equipment: drives the modem lines of the opposite role per port
`timescale 1ns/10ps
module scsl_line_model (
    // clock
    input  wire logic       core_clk_in,
    // role (1 = circuit side), link wanted, noise
    input  wire logic [3:0] mode_in,
    input  wire logic [3:0] up_in,
    input  wire logic [7:0] noise_in,
    // modem lines toward the card
    output logic      [3:0] dsr_out,
    output logic      [3:0] dcd_out,
    output logic      [3:0] cts_out,
    output logic      [3:0] dtr_out,
    output logic      [3:0] rts_out
);
    // a port not up drops one role line
    always @(posedge core_clk_in) begin
        for (int p = 0; p < 4; p++) begin
            if (!mode_in[p]) begin
                {dsr_out[p], dcd_out[p], cts_out[p]} <= up_in[p] ? 3'h7 :
                    3'h7 ^ (3'h1 << (noise_in[2*p+:2] % 3));
                {dtr_out[p], rts_out[p]} <= noise_in[2*p+:2];
            end else begin
                {dtr_out[p], rts_out[p]} <= up_in[p] ? 2'h3 : (noise_in[2*p] ? 2'h1 : 2'h2);
                {dsr_out[p], dcd_out[p], cts_out[p]} <= {3{noise_in[2*p+1]}};
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the slot decode and lamp status block
`timescale 1ns/10ps
module tb_top;
    import scsl_pkg::*;
    localparam int BLINK = 8;
    logic        core_clk_in, sys_rst_in, reg_wr_in, reg_rd_in, slot_valid_out, switch_bad_out;
    logic        irq_out, val2, bad2;
    logic [7:0]  reg_addr_in, noise;
    logic [31:0] reg_wdata_in, reg_rdata_out, port_name_out, name2, e4, e2, r;
    logic [2:0]  rotary_switch_in;
    logic [3:0]  dsr_in, dcd_in, cts_in, dtr_in, rts_in, tx_frame_in, rx_frame_in;
    logic [3:0]  card_slot_number_out, slot2, act4, link4, act2, link2, mode_v, up_v;
    int          miscompares, cmp_count, seed, cyc, pos, n;
    scsl_top #(.PORT_COUNT(4), .BLINK_CYCLES_P(BLINK)) u_dut (
        .core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .rotary_switch_in, .dsr_in, .dcd_in, .cts_in, .dtr_in, .rts_in,
        .tx_frame_in, .rx_frame_in, .card_slot_number_out, .slot_valid_out, .switch_bad_out,
        .port_name_out, .port0_activity_led_out(act4[0]), .port0_link_led_out(link4[0]),
        .port1_activity_led_out(act4[1]), .port1_link_led_out(link4[1]),
        .port2_activity_led_out(act4[2]), .port2_link_led_out(link4[2]),
        .port3_activity_led_out(act4[3]), .port3_link_led_out(link4[3]), .irq_out);
    scsl_top #(.PORT_COUNT(2), .BLINK_CYCLES_P(BLINK)) u_dut_two (
        .core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out(), .rotary_switch_in, .dsr_in, .dcd_in, .cts_in, .dtr_in, .rts_in,
        .tx_frame_in, .rx_frame_in, .card_slot_number_out(slot2), .slot_valid_out(val2),
        .switch_bad_out(bad2), .port_name_out(name2),
        .port0_activity_led_out(act2[0]), .port0_link_led_out(link2[0]),
        .port1_activity_led_out(act2[1]), .port1_link_led_out(link2[1]),
        .port2_activity_led_out(act2[2]), .port2_link_led_out(link2[2]),
        .port3_activity_led_out(act2[3]), .port3_link_led_out(link2[3]), .irq_out());
    scsl_line_model u_line (
        .core_clk_in, .mode_in(mode_v), .up_in(up_v), .noise_in(noise), .dsr_out(dsr_in),
        .dcd_out(dcd_in), .cts_out(cts_in), .dtr_out(dtr_in), .rts_out(rts_in));
    initial begin
        core_clk_in = 1'b0;
        forever #50 core_clk_in = ~core_clk_in;
    end
    // hang guard
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            finish_test;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask
    // wait c edges, sample settled
    task automatic settle(input int c);
        repeat (c) @(posedge core_clk_in);
        #1;
    endtask
    // one-cycle frame pulse, rx when dir
    task automatic pulse(input int p, input bit dir);
        @(posedge core_clk_in);
        if (dir) rx_frame_in[p] <= 1'b1;
        else tx_frame_in[p] <= 1'b1;
        @(posedge core_clk_in);
        {tx_frame_in, rx_frame_in} <= 8'h00;
        #1;
    endtask
    task automatic blink_len(input int p, output int c);
        c = 0;
        while (act4[p] === 1'b1 && c < 50) begin
            c++;
            settle(1);
        end
    endtask
    // names: byte p = slot, index; zero when refused
    function automatic logic [31:0] exp_name(input int ps, input int np);
        int          vmax = (np == 4) ? VALID_POS_FOUR : VALID_POS_TWO;
        logic [31:0] v;
        v = '0;
        for (int p = 0; p < np; p++)
            if (ps < vmax) v[8*p+:8] = {4'(ps + 1), 4'(p)};
        return v;
    endfunction
    initial begin
        {sys_rst_in, seed, cyc, miscompares, cmp_count} = {1'b1, 32'd43977, 96'd0};
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, rotary_switch_in} = '0;
        {tx_frame_in, rx_frame_in, mode_v, up_v, noise} = '0;
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        rd_chk(MODE_OFFS, 32'h0);
        rd_chk(IRQ_MASK_OFFS, 32'h0);
        // all eight positions, both variants
        for (int i = 0; i < 8; i++) begin
            pos = (i * 5 + 3) % 8;
            @(posedge core_clk_in);
            rotary_switch_in <= pos[2:0];
            settle(5);
            e4 = exp_name(pos, 4);
            e2 = exp_name(pos, 2);
            chk(port_name_out, e4);
            chk(name2, e2);
            chk({slot_valid_out, switch_bad_out, card_slot_number_out},
                {e4[7:4] != 0, e4[7:4] == 0, e4[7:4]});
            chk({val2, bad2, slot2}, {e2[7:4] != 0, e2[7:4] == 0, e2[7:4]});
            rd_chk(SLOT_OFFS, {21'h0, pos[2:0], 2'h0, e4[7:4] == 0, e4[7:4] != 0, e4[7:4]});
        end
        @(posedge core_clk_in);
        rotary_switch_in <= 3'h1;
        // random roles and line states per port
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            wr_reg(MODE_OFFS, {28'h0, r[3:0]});
            @(posedge core_clk_in);
            {noise, up_v, mode_v} <= r[15:0];
            settle(6);
            chk(link4, r[7:4]);
            chk(link2, {2'h0, r[5:4]});
            rd_chk(MODE_OFFS, {28'h0, r[3:0]});
            rd_chk(LED_OFFS, {24'h0, r[7:4]});
        end
        // sticky events and interrupt mask
        wr_reg(IRQ_STAT_OFFS, 32'h1f);
        wr_reg(IRQ_MASK_OFFS, 32'h1f);
        rd_chk(IRQ_STAT_OFFS, 32'h0);
        @(posedge core_clk_in);
        up_v <= up_v ^ 4'h2;
        settle(6);
        chk(irq_out, 1'b1);
        rd_chk(IRQ_STAT_OFFS, 32'h4);
        wr_reg(IRQ_MASK_OFFS, 32'h1);
        chk(irq_out, 1'b0);
        wr_reg(IRQ_STAT_OFFS, 32'h4);
        rd_chk(IRQ_STAT_OFFS, 32'h0);
        @(posedge core_clk_in);
        rotary_switch_in <= 3'h4;
        settle(6);
        chk(irq_out, 1'b1);
        rd_chk(IRQ_STAT_OFFS, 32'h1);
        rd_chk(8'hfc, 32'h0);
        // per port: one blink, then a restarted one
        for (int p = 0; p < 4; p++) begin
            pulse(p, 1'b0);
            chk(act2[p], p < 2);
            blink_len(p, n);
            chk(n, BLINK);
            pulse(p, 1'b0);
            pulse(p, 1'b1);
            blink_len(p, n);
            chk(n, BLINK);
        end
        finish_test;
    end
endmodule
